// File: rtl/cpic_top.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module cpic_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [15:0] request_line,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic        host_unit,
    input  wire logic        host_port,
    input  wire logic [7:0]  host_wdata,
    input  wire logic        ack_first,
    input  wire logic        ack_second,
    output logic      [7:0]  rd_data_r,
    output logic             rd_vld_r,
    output logic             int_out_r,
    output logic      [7:0]  vec_r,
    output logic             vec_vld_r
);
    logic [15:0]            sync1_r;
    logic [15:0]            sync2_r;
    logic [7:0]             request_register   [2];
    logic [7:0]             clr   [2];
    logic [7:0]             mask_r [2];
    logic [7:0]             mask_nxt [2];
    logic [7:0]             svc_r [2];
    logic [7:0]             svc_nxt [2];
    logic [7:0]             poll_byte_r [2];
    logic [7:0]             poll_byte_nxt [2];
    logic [4:0]             base_r [2];
    logic [4:0]             base_nxt [2];
    logic                   level_r [2];
    logic                   level_nxt [2];
    logic                   need4_r [2];
    logic                   need4_nxt [2];
    logic                   sfnm_r [2];
    logic                   sfnm_nxt [2];
    logic                   rsel_r [2];
    logic                   rsel_nxt [2];
    logic                   poll_r [2];
    logic                   poll_nxt [2];
    cpic_pkg::cpic_init_t   step_r [2];
    cpic_pkg::cpic_init_t   step_nxt [2];
    logic [7:0]             vec_hold_r;
    logic [7:0]             vec_hold_nxt;
    logic [7:0]             rd_data_nxt;
    logic                   rd_vld_nxt;
    logic [7:0]             vec_nxt;
    logic                   vec_vld_nxt;
    logic [7:0]             eff_m;
    logic [7:0]             pend_m;
    logic [7:0]             pend_t;
    logic                   int_m;
    logic                   int_t;
    logic [2:0]             hp_m;
    logic [2:0]             hp_t;
    logic [2:0]             casc_sel;
    logic                   u;
    logic [2:0]             lvl;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and request latches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end else if (clk_en) begin
            sync1_r <= request_line;
            sync2_r <= sync1_r;
        end
    end

    cpic_req_latch u_latch_m (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .line_in    (sync2_r[7:0]),
        .level_mode (level_r[0]),
        .clr        (clr[0]),
        .req_r      (request_register[0])
    );

    cpic_req_latch u_latch_t (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .line_in    (sync2_r[15:8]),
        .level_mode (level_r[1]),
        .clr        (clr[1]),
        .req_r      (request_register[1])
    );

    //////////////////////////////////////////////////////////////////////////
    // Priority resolution, target feeds master cascade line
    always_comb begin
        pend_t   = request_register[1] & ~mask_r[1];
        hp_t     = cpic_pkg::cpic_first(pend_t);
        int_t    = cpic_pkg::cpic_grant(pend_t, svc_r[1], 1'b0);
        eff_m    = request_register[0];
        eff_m[cpic_pkg::CPIC_CASC_LINE] = int_t;
        pend_m   = eff_m & ~mask_r[0];
        hp_m     = cpic_pkg::cpic_first(pend_m);
        int_m    = cpic_pkg::cpic_grant(pend_m, svc_r[0], sfnm_r[0]);
        casc_sel = hp_m;
    end

    //////////////////////////////////////////////////////////////////////////
    // Command, read and acknowledge handling
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mask_nxt[i]      = mask_r[i];
            svc_nxt[i]       = svc_r[i];
            poll_byte_nxt[i] = poll_byte_r[i];
            base_nxt[i]      = base_r[i];
            level_nxt[i]     = level_r[i];
            need4_nxt[i]     = need4_r[i];
            sfnm_nxt[i]      = sfnm_r[i];
            rsel_nxt[i]      = rsel_r[i];
            poll_nxt[i]      = poll_r[i];
            step_nxt[i]      = step_r[i];
            clr[i]           = cpic_pkg::CPIC_RST_BYTE;
        end
        u            = host_unit;
        lvl          = poll_byte_r[u][2:0];
        vec_hold_nxt = vec_hold_r;
        rd_data_nxt  = rd_data_r;
        rd_vld_nxt   = host_rd;
        vec_nxt      = vec_r;
        vec_vld_nxt  = ack_second;
        if (host_wr && !host_port && host_wdata[cpic_pkg::CPIC_IW1_SEL]) begin
            level_nxt[u] = host_wdata[cpic_pkg::CPIC_IW1_LEVEL];
            need4_nxt[u] = host_wdata[cpic_pkg::CPIC_IW1_NEED4];
            mask_nxt[u]  = cpic_pkg::CPIC_RST_BYTE;
            svc_nxt[u]   = cpic_pkg::CPIC_RST_BYTE;
            sfnm_nxt[u]  = 1'b0;
            rsel_nxt[u]  = 1'b0;
            poll_nxt[u]  = 1'b0;
            step_nxt[u]  = cpic_pkg::CPIC_INIT_W2;
        end else if (host_wr && !host_port && host_wdata[cpic_pkg::CPIC_OW3_SEL]) begin
            poll_nxt[u] = host_wdata[cpic_pkg::CPIC_OW3_POLL];
            // Freeze the level at the poll command
            poll_byte_nxt[u] = {(u ? int_t : int_m), cpic_pkg::CPIC_POLL_PAD,
                                (u ? hp_t : hp_m)};
            if (host_wdata[cpic_pkg::CPIC_OW3_RDREG]) begin
                rsel_nxt[u] = host_wdata[cpic_pkg::CPIC_OW3_RDSVC];
            end
        end else if (host_wr && !host_port && host_wdata[cpic_pkg::CPIC_OW2_EOI]) begin
            if (host_wdata[cpic_pkg::CPIC_OW2_SPEC]) begin
                svc_nxt[u][host_wdata[2:0]] = 1'b0;
            end else if (|svc_r[u]) begin
                svc_nxt[u][cpic_pkg::cpic_first(svc_r[u])] = 1'b0;
            end
        end else if (host_wr && host_port) begin
            case (step_r[u])
                cpic_pkg::CPIC_INIT_W2: begin
                    base_nxt[u] = host_wdata[7:3];
                    step_nxt[u] = cpic_pkg::CPIC_INIT_W3;
                end
                cpic_pkg::CPIC_INIT_W3: begin
                    step_nxt[u] = need4_r[u] ? cpic_pkg::CPIC_INIT_W4 : cpic_pkg::CPIC_INIT_IDLE;
                end
                cpic_pkg::CPIC_INIT_W4: begin
                    sfnm_nxt[u] = host_wdata[cpic_pkg::CPIC_IW4_SFNM];
                    step_nxt[u] = cpic_pkg::CPIC_INIT_IDLE;
                end
                default: begin
                    mask_nxt[u] = host_wdata;
                end
            endcase
        end
        if (host_rd) begin
            if (host_port) begin
                rd_data_nxt = mask_r[u];
            end else if (poll_r[u]) begin
                rd_data_nxt = poll_byte_r[u];
                poll_nxt[u] = 1'b0;
                if (poll_byte_r[u][cpic_pkg::CPIC_POLL_INT]) begin
                    svc_nxt[u][lvl] = 1'b1;
                    clr[u][lvl]     = 1'b1;
                end
            end else begin
                rd_data_nxt = rsel_r[u] ? svc_r[u] : (u ? request_register[1] : eff_m);
            end
        end
        if (ack_first) begin
            if (!int_m) begin
                vec_hold_nxt = {base_r[0], cpic_pkg::CPIC_SPUR_LINE};
            end else if (casc_sel == cpic_pkg::CPIC_CASC_LINE) begin
                svc_nxt[0][casc_sel] = 1'b1;
                if (int_t) begin
                    svc_nxt[1][hp_t] = 1'b1;
                    clr[1][hp_t]     = 1'b1;
                    vec_hold_nxt     = {base_r[1], hp_t};
                end else begin
                    vec_hold_nxt     = {base_r[1], cpic_pkg::CPIC_SPUR_LINE};
                end
            end else begin
                svc_nxt[0][hp_m] = 1'b1;
                clr[0][hp_m]     = 1'b1;
                vec_hold_nxt     = {base_r[0], hp_m};
            end
        end
        if (ack_second) begin
            vec_nxt = vec_hold_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                mask_r[i]      <= cpic_pkg::CPIC_RST_BYTE;
                svc_r[i]       <= cpic_pkg::CPIC_RST_BYTE;
                poll_byte_r[i] <= cpic_pkg::CPIC_RST_BYTE;
                base_r[i]      <= cpic_pkg::CPIC_RST_BASE;
                level_r[i]     <= 1'b0;
                need4_r[i]     <= 1'b0;
                sfnm_r[i]      <= 1'b0;
                rsel_r[i]      <= 1'b0;
                poll_r[i]      <= 1'b0;
                step_r[i]      <= cpic_pkg::CPIC_INIT_IDLE;
            end
            vec_hold_r <= cpic_pkg::CPIC_RST_BYTE;
            rd_data_r  <= cpic_pkg::CPIC_RST_BYTE;
            rd_vld_r   <= 1'b0;
            vec_r      <= cpic_pkg::CPIC_RST_BYTE;
            vec_vld_r  <= 1'b0;
            int_out_r  <= 1'b0;
        end else if (clk_en) begin
            mask_r      <= mask_nxt;
            svc_r       <= svc_nxt;
            poll_byte_r <= poll_byte_nxt;
            base_r      <= base_nxt;
            level_r     <= level_nxt;
            need4_r     <= need4_nxt;
            sfnm_r      <= sfnm_nxt;
            rsel_r      <= rsel_nxt;
            poll_r      <= poll_nxt;
            step_r      <= step_nxt;
            vec_hold_r  <= vec_hold_nxt;
            rd_data_r   <= rd_data_nxt;
            rd_vld_r    <= rd_vld_nxt;
            vec_r       <= vec_nxt;
            vec_vld_r   <= vec_vld_nxt;
            int_out_r   <= int_m;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] svc_m;
    logic [7:0] poll_m;
    logic       rd_m_cmd;
    assign svc_m    = svc_r[0];
    assign poll_m   = poll_byte_r[0];
    assign rd_m_cmd = clk_en && host_rd && !host_unit && !host_port;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_poll_format: assert property (rd_m_cmd && poll_r[0] |=> rd_data_r == $past(poll_m) && rd_vld_r)
        else $error("poll byte wrong");
    a_svc_read: assert property (rd_m_cmd && !poll_r[0] && rsel_r[0] |=> rd_data_r == $past(svc_m))
        else $error("in-service read wrong");
    a_poll_wins: assert property (clk_en && host_wr && !host_unit && !host_port && host_wdata == 8'h0E
        ##2 rd_m_cmd |=> rd_data_r[6:3] == 4'h0)
        else $error("register read beat poll");
    a_poll_ack: assert property (rd_m_cmd && poll_r[0] && poll_m[7] && !ack_first
        |=> svc_m[$past(poll_m[2:0])] && !poll_r[0])
        else $error("poll read did not acknowledge");
    a_spur_vector: assert property (clk_en && ack_first && !int_m |=> vec_hold_r[2:0] == 3'h7)
        else $error("spurious vector not level seven");
    a_spur_clean: assert property (clk_en && ack_first && !int_m && !host_wr && !host_rd
        |=> svc_m == $past(svc_m))
        else $error("spurious acknowledge set in-service");
    a_sfnm_pass: assert property (sfnm_r[0] && svc_m == 8'h04 && int_t && !mask_r[0][2] |-> int_m)
        else $error("target locked out in special nesting");
    a_nest_lock: assert property (!sfnm_r[0] && svc_m[2] && int_m |-> hp_m < 3'h2)
        else $error("target not masked in normal nesting");
    a_int_follow: assert property (clk_en |=> int_out_r == $past(int_m))
        else $error("interrupt output lags");
    a_casc_vec: assert property (clk_en && ack_first && int_m && hp_m == 3'h2 && int_t
        |=> vec_hold_r[2:0] == $past(hp_t) && svc_m[2])
        else $error("cascade vector wrong");

    c_poll_read: cover property (rd_m_cmd && poll_r[0] && poll_m[7]);
    c_spurious: cover property (clk_en && ack_first && !int_m);
    c_casc_ack: cover property (clk_en && ack_first && int_m && hp_m == 3'h2 ##[1:8] ack_second);
endmodule

// File: rtl/cpic_pkg.sv
package cpic_pkg;
    localparam int          CPIC_UNITS      = 2;
    localparam int          CPIC_LINES      = 16;
    localparam logic [2:0]  CPIC_CASC_LINE  = 3'h2;
    localparam logic [2:0]  CPIC_SPUR_LINE  = 3'h7;
    // Command byte fields, and the poll byte interrupt bit
    localparam int          CPIC_IW1_SEL    = 4;
    localparam int          CPIC_IW1_LEVEL  = 3;
    localparam int          CPIC_IW1_NEED4  = 0;
    localparam int          CPIC_OW3_SEL    = 3;
    localparam int          CPIC_OW3_POLL   = 2;
    localparam int          CPIC_OW3_RDREG  = 1;
    localparam int          CPIC_OW3_RDSVC  = 0;
    localparam int          CPIC_OW2_EOI    = 5;
    localparam int          CPIC_OW2_SPEC   = 6;
    localparam int          CPIC_IW4_SFNM   = 4;
    localparam int          CPIC_POLL_INT   = 7;
    // Values after reset, and poll byte padding
    localparam logic [7:0]  CPIC_RST_BYTE   = 8'h00;
    localparam logic [4:0]  CPIC_RST_BASE   = 5'h01;
    localparam logic [3:0]  CPIC_POLL_PAD   = 4'h0;

    typedef enum logic [1:0] {
        CPIC_INIT_IDLE = 2'b00,
        CPIC_INIT_W2   = 2'b01,
        CPIC_INIT_W3   = 2'b10,
        CPIC_INIT_W4   = 2'b11
    } cpic_init_t;

    // Highest priority set bit, level 0 highest
    function automatic logic [2:0] cpic_first(input logic [7:0] v);
        logic [2:0] r;
        r = CPIC_SPUR_LINE;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Request beats all levels in service, or ties the highest one in special nesting
    function automatic logic cpic_grant(input logic [7:0] pend, input logic [7:0] svc, input logic sfnm);
        logic ok;
        ok = (svc == CPIC_RST_BYTE) || (sfnm ? (cpic_first(pend) <= cpic_first(svc))
                                              : (cpic_first(pend) < cpic_first(svc)));
        return (|pend) && ok;
    endfunction
endpackage

// File: rtl/cpic_req_latch.sv
`timescale 1ns/100ps
module cpic_req_latch (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [7:0] line_in,
    input  wire logic       level_mode,
    input  wire logic [7:0] clr,
    output logic      [7:0] req_r
);
    logic [7:0] prev_r;
    logic [7:0] prev_nxt;
    logic [7:0] req_nxt;

    always_comb begin
        prev_nxt = line_in;
        if (level_mode) begin
            req_nxt = line_in;
        end else begin
            // Edge held only while line stays high
            req_nxt = ((req_r & ~clr) | (line_in & ~prev_r)) & line_in;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= cpic_pkg::CPIC_RST_BYTE;
            req_r  <= cpic_pkg::CPIC_RST_BYTE;
        end else if (clk_en) begin
            prev_r <= prev_nxt;
            req_r  <= req_nxt;
        end
    end

    a_edge_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && !level_mode && |(line_in & ~prev_r))
        |=> ((req_r & $past(line_in & ~prev_r)) == $past(line_in & ~prev_r)))
        else $error("edge request not latched");
endmodule

// File: tb/cpic_host_model.sv
`timescale 1ns/100ps
module cpic_host_model (
    input  wire logic       core_clk,
    input  wire logic       auto_en,
    input  wire logic       go,
    input  wire logic [3:0] slow,
    input  wire logic       int_out_r,
    input  wire logic       vec_vld_r,
    input  wire logic [7:0] vec_r,
    output logic            ack_first,
    output logic            ack_second,
    output logic      [7:0] vec_seen,
    output logic      [7:0] n_vec
);
    // Acknowledge pair on interrupt, or on demand even without one
    initial begin
        ack_first  = 1'b0;
        ack_second = 1'b0;
        vec_seen   = 8'h00;
        n_vec      = 8'h00;
        forever begin
            @(posedge core_clk);
            if ((auto_en && int_out_r) || go) begin
                @(negedge core_clk);
                ack_first = 1'b1;
                @(negedge core_clk);
                ack_first = 1'b0;
                repeat (slow) @(negedge core_clk);
                ack_second = 1'b1;
                @(negedge core_clk);
                ack_second = 1'b0;
                if (vec_vld_r === 1'b1) begin
                    vec_seen = vec_r;
                    n_vec    = n_vec + 8'h01;
                end
                // Interrupt output drops a cycle late
                repeat (3) @(negedge core_clk);
            end
        end
    end
endmodule

// File: tb/cascaded_pic_status_and_nesting_tb.sv
`timescale 1ns/100ps
module cascaded_pic_status_and_nesting_tb;
    logic        core_clk     = 1'b0;
    logic        rst_n        = 1'b0;
    logic        clk_en       = 1'b1;
    logic [15:0] request_line = '0;
    logic        host_wr      = 1'b0;
    logic        host_rd      = 1'b0;
    logic        host_unit    = 1'b0;
    logic        host_port    = 1'b0;
    logic [7:0]  host_wdata   = 8'h00;
    logic        auto_en      = 1'b0;
    logic        go           = 1'b0;
    logic [3:0]  slow         = 4'h0;
    logic        ack_first, ack_second, rd_vld_r, int_out_r, vec_vld_r;
    logic [7:0]  rd_data_r, vec_r, vec_seen, n_vec;
    int          n_errors     = 0;
    int          n_checks     = 0;

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    cpic_top DUT (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .request_line(request_line),
        .host_wr    (host_wr),
        .host_rd    (host_rd),
        .host_unit  (host_unit),
        .host_port  (host_port),
        .host_wdata (host_wdata),
        .ack_first  (ack_first),
        .ack_second (ack_second),
        .rd_data_r  (rd_data_r),
        .rd_vld_r   (rd_vld_r),
        .int_out_r  (int_out_r),
        .vec_r      (vec_r),
        .vec_vld_r  (vec_vld_r)
    );

    cpic_host_model host (
        .core_clk   (core_clk),
        .auto_en    (auto_en),
        .go         (go),
        .slow       (slow),
        .int_out_r  (int_out_r),
        .vec_vld_r  (vec_vld_r),
        .vec_r      (vec_r),
        .ack_first  (ack_first),
        .ack_second (ack_second),
        .vec_seen   (vec_seen),
        .n_vec      (n_vec)
    );

    //////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic unit, input logic port, input logic [7:0] data);
        @(negedge core_clk);
        host_wr    = 1'b1;
        host_unit  = unit;
        host_port  = port;
        host_wdata = data;
        @(negedge core_clk);
        host_wr = 1'b0;
    endtask

    task automatic rd(input logic unit, input logic port, input logic [7:0] exp, input string what);
        @(negedge core_clk);
        host_rd   = 1'b1;
        host_unit = unit;
        host_port = port;
        @(negedge core_clk);
        host_rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, rd_vld_r});
        chk(what, exp, rd_data_r);
    endtask

    task automatic rdreg(input logic unit, input logic [7:0] cmd, input logic [7:0] exp, input string what);
        wr(unit, 1'b0, cmd);
        rd(unit, 1'b0, exp, what);
    endtask

    task automatic init(input logic unit, input logic [7:0] w1, input logic [7:0] base, input logic [7:0] w4);
        wr(unit, 1'b0, w1);
        wr(unit, 1'b1, base);
        wr(unit, 1'b1, unit ? 8'h02 : 8'h04);
        wr(unit, 1'b1, w4);
    endtask

    task automatic settle();
        repeat (8) @(negedge core_clk);
    endtask

    task automatic wait_vec(input logic [7:0] exp);
        logic [7:0] start;
        int         i;
        start = n_vec;
        i     = 0;
        while (n_vec === start && i < 300) begin
            @(negedge core_clk);
            i++;
        end
        if (n_vec === start) begin
            n_errors++;
            $display("BAD vector expected %h seen none", exp);
            summarize();
        end else begin
            chk("vector", exp, vec_seen);
        end
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        rdreg(1'b0, 8'h0A, 8'h00, "request after reset");
        rd(1'b0, 1'b1, 8'h00, "mask after reset");
        init(1'b0, 8'h11, 8'h08, 8'h00);
        init(1'b1, 8'h11, 8'h70, 8'h00);
        wr(1'b0, 1'b1, 8'hA5);
        rd(1'b0, 1'b1, 8'hA5, "mask");
        // Write ignored while clock enable is low
        clk_en = 1'b0;
        wr(1'b0, 1'b1, 8'h3C);
        clk_en = 1'b1;
        rd(1'b0, 1'b1, 8'hA5, "mask frozen");
        wr(1'b0, 1'b1, 8'h00);
        // Poll with register read also requested
        request_line[5] = 1'b1;
        settle();
        rdreg(1'b0, 8'h0A, 8'h20, "request");
        rdreg(1'b0, 8'h0E, 8'h85, "poll byte");
        rdreg(1'b0, 8'h0B, 8'h20, "in service");
        rd(1'b0, 1'b0, 8'h20, "in service again");
        request_line[5] = 1'b0;
        wr(1'b0, 1'b0, 8'h20);
        // Edge acknowledge, then line left high
        auto_en         = 1'b1;
        request_line[3] = 1'b1;
        wait_vec(8'h0B);
        rdreg(1'b0, 8'h0B, 8'h08, "in service");
        wr(1'b0, 1'b0, 8'h20);
        settle();
        chk("no retrigger", 8'h00, {7'h00, int_out_r});
        // Request dropped before acknowledge
        auto_en         = 1'b0;
        request_line[4] = 1'b1;
        settle();
        chk("interrupt", 8'h01, {7'h00, int_out_r});
        request_line[4] = 1'b0;
        settle();
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        wait_vec(8'h0F);
        rdreg(1'b0, 8'h0B, 8'h00, "spurious in service");
        // Normal nesting locks out the target
        auto_en          = 1'b1;
        slow             = 4'h3;
        request_line[13] = 1'b1;
        wait_vec(8'h75);
        rdreg(1'b0, 8'h0B, 8'h04, "cascade in service");
        request_line[9] = 1'b1;
        repeat (12) @(negedge core_clk);
        chk("target locked out", 8'h00, {7'h00, int_out_r});
        wr(1'b1, 1'b0, 8'h20);
        wr(1'b0, 1'b0, 8'h20);
        wait_vec(8'h71);
        wr(1'b1, 1'b0, 8'h20);
        wr(1'b0, 1'b0, 8'h20);
        request_line[13] = 1'b0;
        request_line[9]  = 1'b0;
        auto_en          = 1'b0;
        settle();
        // Special nesting lets the target through
        init(1'b0, 8'h11, 8'h08, 8'h10);
        auto_en          = 1'b1;
        request_line[13] = 1'b1;
        wait_vec(8'h75);
        request_line[9] = 1'b1;
        wait_vec(8'h71);
        wr(1'b1, 1'b0, 8'h20);
        rdreg(1'b1, 8'h0B, 8'h20, "target in service");
        wr(1'b1, 1'b0, 8'h20);
        rdreg(1'b1, 8'h0B, 8'h00, "target in service");
        wr(1'b0, 1'b0, 8'h20);
        rdreg(1'b0, 8'h0B, 8'h00, "master in service");
        request_line[13] = 1'b0;
        request_line[9]  = 1'b0;
        // Level mode sees a line that never moved
        auto_en = 1'b0;
        slow    = 4'h0;
        init(1'b0, 8'h19, 8'h08, 8'h00);
        auto_en = 1'b1;
        wait_vec(8'h0B);
        request_line[3] = 1'b0;
        settle();
        wr(1'b0, 1'b0, 8'h20);
        settle();
        chk("level cleared", 8'h00, {7'h00, int_out_r});
        summarize();
    end
endmodule
